// file: core/rps_pkg.sv
// Package for the receive payload / signaling register bank.
// Assumes a 125 MHz system clock and a word-aligned Avalon-MM slave port.
package rps_pkg;
  // Register indices (byte address is four times the index)
  localparam logic [7:0] RPS_IDX_PAY_STATUS = 8'hCD;
  localparam logic [7:0] RPS_IDX_PAY_CTL = 8'hCE;
  localparam logic [7:0] RPS_IDX_PAY_DATA = 8'hCF;
  localparam logic [7:0] RPS_IDX_PAY_CFG = 8'hD0;
  localparam logic [7:0] RPS_IDX_PAY_EN = 8'hD1;
  localparam logic [7:0] RPS_IDX_SIG_CFG = 8'hD2;
  localparam logic [7:0] RPS_IDX_SIG_STATUS = 8'hD3;
  localparam logic [7:0] RPS_IDX_SIG_CTL = 8'hD4;
  localparam logic [7:0] RPS_IDX_SIG_DATA = 8'hD5;
  localparam logic [7:0] RPS_IDX_FLAGS0 = 8'hD6;
  localparam logic [7:0] RPS_IDX_FLAGS1 = 8'hD7;
  localparam logic [7:0] RPS_IDX_FLAGS2 = 8'hD8;
  // Reset values and writable-bit masks
  localparam logic [7:0] RPS_PAY_CFG_RST = 8'h80;
  localparam logic [7:0] RPS_PAY_CFG_MASK = 8'hC7;
  localparam logic [7:0] RPS_PAY_EN_RST = 8'h00;
  localparam logic [7:0] RPS_PAY_EN_MASK = 8'h0F;
  localparam logic [7:0] RPS_SIG_CFG_RST = 8'h01;
  localparam logic [7:0] RPS_SIG_CFG_MASK = 8'h0F;
  // Field positions
  localparam int RPS_CTL_READ_BIT = 7;
  localparam int RPS_CFG_SNAPSHOT_BIT = 6 + 1;
  localparam int RPS_CFG_GTRUNK_BIT = 6;
  localparam int RPS_EN_POSITION_BIT = 3;
  localparam int RPS_EN_FORCE_BIT = 2;
  localparam int RPS_EN_LEVEL_BIT = 1;
  localparam int RPS_EN_ENABLE_BIT = 0;
  localparam int RPS_SCFG_FREEZE_BIT = 3;
  localparam int RPS_SCFG_DEBOUNCE_BIT = 2;
  localparam int RPS_SCFG_IRQ_EN_BIT = 1;
  localparam int RPS_SCFG_SIXTEEN_BIT = 0;
  localparam int RPS_TRUNK_EN_BIT = 4;
  // Indirect groups of the payload port
  localparam logic [1:0] RPS_GRP_CHANNEL_PAYLOAD_SUBSTITUTION = 2'h0;
  localparam logic [1:0] RPS_GRP_DTRUNK = 2'h1;
  localparam logic [1:0] RPS_GRP_STRUNK = 2'h2;
  // Substitution codes, global and per channel
  localparam logic [2:0] RPS_SUB_NONE = 3'h0;
  localparam logic [2:0] RPS_SUB_TRUNK = 3'h1;
  localparam logic [2:0] RPS_SUB_ALAW = 3'h2;
  localparam logic [2:0] RPS_SUB_MULAW = 3'h3;
endpackage : rps_pkg

// file: core/rps_regs.sv
// Register bank for the receive payload controller and receive signaling
// buffer of four T1/J1 links, with the signaling store and payload substitution.
// Assumes framer strobes are synchronous to sys_clk and channels run 0..23.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rps_regs
  import rps_pkg::*;
#(
  parameter int NUM_LINKS = 4,
  parameter int NUM_CHAN = 24,
  // Milliwatt sequences, byte 0 in the low bits; values are set by integration
  parameter logic [63:0] ALAW_MW_PATTERN = 64'h0000000000000000,
  parameter logic [63:0] MULAW_MW_PATTERN = 64'h0000000000000000
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Received signaling from the framer
  input wire logic sig_valid,
  input wire logic [1:0] sig_link,
  input wire logic [4:0] sig_chan,
  input wire logic [7:0] sig_byte,
  input wire logic sig_first_frame,
  input wire logic sig_in_sync,
  input wire logic sig_esf,
  output logic sig_out_valid,
  output logic [1:0] sig_out_link,
  output logic [4:0] sig_out_chan,
  output logic [3:0] rx_signaling_out,
  // Received payload from the framer
  input wire logic pay_valid,
  input wire logic [1:0] pay_link,
  input wire logic [4:0] pay_chan,
  input wire logic [7:0] pay_byte,
  output logic pay_out_valid,
  output logic [1:0] pay_out_link,
  output logic [4:0] pay_out_chan,
  output logic [7:0] pay_out_byte,
  // One interrupt per link
  output logic [NUM_LINKS-1:0] irq
);

  logic [7:0] pay_cfg [NUM_LINKS];
  logic [7:0] pay_en [NUM_LINKS];
  logic [7:0] sig_cfg [NUM_LINKS];
  logic [7:0] pay_ctl [NUM_LINKS];
  logic [7:0] pay_data [NUM_LINKS];
  logic [7:0] sig_ctl [NUM_LINKS];
  logic [7:0] sig_data [NUM_LINKS];
  logic [NUM_LINKS-1:0] pay_busy;
  logic [NUM_LINKS-1:0] sig_busy;
  logic [NUM_CHAN-1:0] flags [NUM_LINKS];
  logic [7:0] pay_mem [NUM_LINKS][3][NUM_CHAN];
  logic [7:0] sig_mem [NUM_LINKS][NUM_CHAN];
  logic [3:0] prev_code [NUM_LINKS][NUM_CHAN];
  logic [3:0] snap_code [NUM_LINKS][NUM_CHAN];
  logic [2:0] mw_phase [NUM_LINKS];

  // Bus decode: link in the top index digit
  logic [1:0] acc_link;
  logic [7:0] acc_off;
  logic acc_link_ok;
  logic bus_wr;
  logic [7:0] wbyte;
  logic [7:0] rd_mux;
  assign acc_link = address[11:10];
  assign acc_off = address[9:2];
  assign acc_link_ok = 32'(acc_link) < NUM_LINKS;
  assign wbyte = writedata[7:0];
  // Write takes effect only at the edge where waitrequest is low
  assign bus_wr = write && !waitrequest && byteenable[0] && acc_link_ok;
  // Read multiplexer; reserved bits and unmapped offsets read zero
  always_comb begin
    rd_mux = 8'h00;
    if (acc_link_ok) begin
      case (acc_off)
        RPS_IDX_PAY_STATUS: rd_mux = {7'h00, pay_busy[acc_link]};
        RPS_IDX_PAY_CTL: rd_mux = pay_ctl[acc_link];
        RPS_IDX_PAY_DATA: rd_mux = pay_data[acc_link];
        RPS_IDX_PAY_CFG: rd_mux = pay_cfg[acc_link];
        RPS_IDX_PAY_EN: rd_mux = pay_en[acc_link];
        RPS_IDX_SIG_CFG: rd_mux = sig_cfg[acc_link];
        RPS_IDX_SIG_STATUS: rd_mux = {7'h00, sig_busy[acc_link]};
        RPS_IDX_SIG_CTL: rd_mux = sig_ctl[acc_link];
        RPS_IDX_SIG_DATA: rd_mux = sig_data[acc_link];
        RPS_IDX_FLAGS0: rd_mux = flags[acc_link][7:0];
        RPS_IDX_FLAGS1: rd_mux = flags[acc_link][15:8];
        RPS_IDX_FLAGS2: rd_mux = flags[acc_link][23:16];
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // One wait cycle per access; read data is captured while waitrequest is high
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata <= {24'h000000, rd_mux};
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // Indirect address decode for both ports
  function automatic logic pay_addr_ok(input logic [7:0] ctl);
    pay_addr_ok = (ctl[4:0] != 5'h00) && (32'(ctl[4:0]) <= NUM_CHAN)
      && (ctl[6:5] != 2'h3);
  endfunction : pay_addr_ok

  function automatic logic sig_addr_ok(input logic [7:0] ctl);
    sig_addr_ok = (ctl[4:0] != 5'h00) && (32'(ctl[4:0]) <= NUM_CHAN)
      && (ctl[6:5] == 2'h0);
  endfunction : sig_addr_ok

  // Direct configuration and access-control registers
  always_ff @(posedge sys_clk) begin
    for (int l = 0; l < NUM_LINKS; l++) begin
      if (!reset_n) begin
        pay_cfg[l] <= RPS_PAY_CFG_RST;
        pay_en[l] <= RPS_PAY_EN_RST;
        sig_cfg[l] <= RPS_SIG_CFG_RST;
        pay_ctl[l] <= 8'h00;
        sig_ctl[l] <= 8'h00;
      end else if (bus_wr && 32'(acc_link) == l) begin
        case (acc_off)
          RPS_IDX_PAY_CFG: pay_cfg[l] <= wbyte & RPS_PAY_CFG_MASK;
          RPS_IDX_PAY_EN: pay_en[l] <= wbyte & RPS_PAY_EN_MASK;
          RPS_IDX_SIG_CFG: sig_cfg[l] <= wbyte & RPS_SIG_CFG_MASK;
          // Control held still while busy so the running transfer keeps its target
          RPS_IDX_PAY_CTL: if (!pay_busy[l]) pay_ctl[l] <= wbyte;
          RPS_IDX_SIG_CTL: if (!sig_busy[l]) sig_ctl[l] <= wbyte;
          default: ;
        endcase
      end
    end
  end

  // Busy: set by the control write, cleared after the one-cycle transfer
  always_ff @(posedge sys_clk) begin
    for (int l = 0; l < NUM_LINKS; l++) begin
      if (!reset_n) begin
        pay_busy[l] <= 1'b0;
        sig_busy[l] <= 1'b0;
      end else begin
        if (pay_busy[l]) begin
          pay_busy[l] <= 1'b0;
        end else if (bus_wr && 32'(acc_link) == l && acc_off == RPS_IDX_PAY_CTL) begin
          pay_busy[l] <= 1'b1;
        end
        if (sig_busy[l]) begin
          sig_busy[l] <= 1'b0;
        end else if (bus_wr && 32'(acc_link) == l && acc_off == RPS_IDX_SIG_CTL) begin
          sig_busy[l] <= 1'b1;
        end
      end
    end
  end

  // Access data: host writes, overwritten by an indirect read as busy drops
  always_ff @(posedge sys_clk) begin
    for (int l = 0; l < NUM_LINKS; l++) begin
      if (!reset_n) begin
        pay_data[l] <= 8'h00;
        sig_data[l] <= 8'h00;
      end else begin
        if (pay_busy[l] && pay_ctl[l][RPS_CTL_READ_BIT]) begin
          pay_data[l] <= pay_addr_ok(pay_ctl[l]) ?
            pay_mem[l][pay_ctl[l][6:5]][pay_ctl[l][4:0] - 5'h01] : 8'h00;
        end else if (bus_wr && 32'(acc_link) == l && acc_off == RPS_IDX_PAY_DATA) begin
          pay_data[l] <= wbyte;
        end
        if (sig_busy[l] && sig_ctl[l][RPS_CTL_READ_BIT]) begin
          sig_data[l] <= sig_addr_ok(sig_ctl[l]) ?
            sig_mem[l][sig_ctl[l][4:0] - 5'h01] : 8'h00;
        end else if (bus_wr && 32'(acc_link) == l && acc_off == RPS_IDX_SIG_DATA) begin
          sig_data[l] <= wbyte;
        end
      end
    end
  end

  // Payload indirect store: substitution, data trunk and signaling trunk codes
  always_ff @(posedge sys_clk) begin
    for (int l = 0; l < NUM_LINKS; l++) begin
      if (!reset_n) begin
        for (int g = 0; g < 3; g++) begin
          for (int c = 0; c < NUM_CHAN; c++) begin
            pay_mem[l][g][c] <= 8'h00;
          end
        end
      end else if (pay_busy[l] && !pay_ctl[l][RPS_CTL_READ_BIT] && pay_addr_ok(pay_ctl[l])) begin
        pay_mem[l][pay_ctl[l][6:5]][pay_ctl[l][4:0] - 5'h01] <= pay_data[l];
      end
    end
  end

  // Signaling extraction for the strobed channel
  logic sig_ok;
  logic [3:0] sig_raw;
  logic [3:0] sig_cur;
  logic [3:0] sig_cand;
  logic sig_upd;
  logic sig_changed;
  logic [3:0] sig_stored;
  logic [7:0] sig_pen;
  logic [7:0] sig_scfg;
  logic [7:0] sig_trunk;
  assign sig_ok = sig_valid && (32'(sig_link) < NUM_LINKS) && (32'(sig_chan) < NUM_CHAN);
  assign sig_pen = pay_en[sig_link];
  assign sig_scfg = sig_cfg[sig_link];
  assign sig_trunk = pay_mem[sig_link][RPS_GRP_STRUNK][sig_chan];
  assign sig_cur = sig_mem[sig_link][sig_chan][3:0];
  // Two-bit position only applies to extended superframe formats
  assign sig_raw = (sig_esf && sig_pen[RPS_EN_POSITION_BIT]) ?
    {sig_byte[3:2], 2'b00} : sig_byte[3:0];
  // Four-state mode keeps C and D untouched in extended superframe formats
  assign sig_cand = (sig_esf && !sig_scfg[RPS_SCFG_SIXTEEN_BIT]) ?
    {sig_raw[3:2], sig_cur[1:0]} : sig_raw;
  assign sig_upd = sig_ok && !sig_scfg[RPS_SCFG_FREEZE_BIT]
    && (!sig_scfg[RPS_SCFG_DEBOUNCE_BIT]
    || sig_cand == prev_code[sig_link][sig_chan]);
  assign sig_changed = sig_upd && (sig_cand != sig_cur);
  assign sig_stored = sig_upd ? sig_cand : sig_cur;

  // Last codeword seen per channel, for debounce comparison
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          prev_code[l][c] <= 4'h0;
          snap_code[l][c] <= 4'h0;
        end
      end
    end else if (sig_ok) begin
      prev_code[sig_link][sig_chan] <= sig_cand;
      if (sig_first_frame) begin
        snap_code[sig_link][sig_chan] <= sig_stored;
      end
    end
  end

  // Signaling store: host indirect writes and extracted ABCD updates
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          sig_mem[l][c] <= 8'h00;
        end
      end
    end else begin
      if (sig_upd) begin
        sig_mem[sig_link][sig_chan][3:0] <= sig_cand;
      end
      // Host write lands after the extraction so the host wins a same-cycle clash
      for (int l = 0; l < NUM_LINKS; l++) begin
        if (sig_busy[l] && !sig_ctl[l][RPS_CTL_READ_BIT] && sig_addr_ok(sig_ctl[l])) begin
          sig_mem[l][sig_ctl[l][4:0] - 5'h01] <= sig_data[l];
        end
      end
    end
  end

  // Change flags: hardware set wins over a same-cycle write-one clear
  always_ff @(posedge sys_clk) begin
    for (int l = 0; l < NUM_LINKS; l++) begin
      if (!reset_n) begin
        flags[l] <= '0;
      end else begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          if (sig_changed && 32'(sig_link) == l && 32'(sig_chan) == c) begin
            flags[l][c] <= 1'b1;
          end else if (bus_wr && 32'(acc_link) == l
              && acc_off == RPS_IDX_FLAGS0 + 8'(c / 8) && wbyte[c % 8]) begin
            flags[l][c] <= 1'b0;
          end
        end
      end
    end
  end

  // Interrupt per link from enabled flags
  always_ff @(posedge sys_clk) begin
    for (int l = 0; l < NUM_LINKS; l++) begin
      if (!reset_n) begin
        irq[l] <= 1'b0;
      end else begin
        irq[l] <= sig_cfg[l][RPS_SCFG_IRQ_EN_BIT] && (|flags[l]);
      end
    end
  end

  // Signaling output: force, then trunk, then snapshot, then stored value
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sig_out_valid <= 1'b0;
      sig_out_link <= 2'h0;
      sig_out_chan <= 5'h00;
      rx_signaling_out <= 4'h0;
    end else begin
      sig_out_valid <= sig_ok;
      sig_out_link <= sig_link;
      sig_out_chan <= sig_chan;
      if (!sig_pen[RPS_EN_ENABLE_BIT]) begin
        rx_signaling_out <= sig_stored;
      end else if (sig_pen[RPS_EN_FORCE_BIT]) begin
        rx_signaling_out <= {4{sig_pen[RPS_EN_LEVEL_BIT]}};
      end else if (pay_cfg[sig_link][RPS_CFG_GTRUNK_BIT] || sig_trunk[RPS_TRUNK_EN_BIT]) begin
        rx_signaling_out <= sig_trunk[3:0];
      end else if (pay_cfg[sig_link][RPS_CFG_SNAPSHOT_BIT] && sig_in_sync
          && !sig_first_frame) begin
        rx_signaling_out <= snap_code[sig_link][sig_chan];
      end else begin
        rx_signaling_out <= sig_stored;
      end
    end
  end

  // Milliwatt phase per link steps once per frame, after the last channel
  always_ff @(posedge sys_clk) begin
    for (int l = 0; l < NUM_LINKS; l++) begin
      if (!reset_n) begin
        mw_phase[l] <= 3'h0;
      end else if (pay_valid && 32'(pay_link) == l && 32'(pay_chan) == NUM_CHAN - 1) begin
        mw_phase[l] <= mw_phase[l] + 3'h1;
      end
    end
  end

  // Payload substitution selection
  logic [2:0] sub_sel;
  logic [7:0] sub_byte;
  logic pay_ok;
  logic [5:0] mw_bit;
  assign pay_ok = pay_valid && (32'(pay_link) < NUM_LINKS) && (32'(pay_chan) < NUM_CHAN);
  assign mw_bit = {mw_phase[pay_link], 3'h0};

  always_comb begin
    sub_sel = pay_cfg[pay_link][2:0];
    if (sub_sel == RPS_SUB_NONE) begin
      sub_sel = pay_mem[pay_link][RPS_GRP_CHANNEL_PAYLOAD_SUBSTITUTION][pay_chan][7:5];
    end
    case (sub_sel)
      RPS_SUB_TRUNK: sub_byte = pay_mem[pay_link][RPS_GRP_DTRUNK][pay_chan];
      RPS_SUB_ALAW: sub_byte = ALAW_MW_PATTERN[mw_bit +: 8];
      RPS_SUB_MULAW: sub_byte = MULAW_MW_PATTERN[mw_bit +: 8];
      default: sub_byte = pay_byte; // Reserved codes pass data through
    endcase
  end

  // Payload output register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pay_out_valid <= 1'b0;
      pay_out_link <= 2'h0;
      pay_out_chan <= 5'h00;
      pay_out_byte <= 8'h00;
    end else begin
      pay_out_valid <= pay_ok;
      pay_out_link <= pay_link;
      pay_out_chan <= pay_chan;
      pay_out_byte <= pay_en[pay_link][RPS_EN_ENABLE_BIT] ? sub_byte : pay_byte;
    end
  end

endmodule : rps_regs
`default_nettype wire

// file: test/rps_checker.sv
// Checker for rps_regs: bus answer timing, signaling and payload outputs.
// Assumes it is bound to rps_regs and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module rps_checker
  import rps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic sig_valid,
  input wire logic [1:0] sig_link,
  input wire logic [4:0] sig_chan,
  input wire logic sig_out_valid,
  input wire logic [1:0] sig_out_link,
  input wire logic [4:0] sig_out_chan,
  input wire logic [3:0] rx_signaling_out,
  input wire logic pay_valid,
  input wire logic [1:0] pay_link,
  input wire logic [7:0] pay_byte,
  input wire logic [7:0] pay_out_byte,
  input wire logic [3:0] irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] en_r [4];
  logic [7:0] cfg_r [4];
  logic cmt, lvl, frc, pen, ie0;
  // Shadow copies, so outputs can be tied to what the host wrote
  assign cmt = write && !waitrequest && byteenable[0];
  assign lvl = en_r[sig_link][1];
  assign frc = en_r[sig_link][0] && en_r[sig_link][2];
  assign pen = en_r[pay_link][0];
  assign ie0 = cfg_r[0][1];
  // Enable register shadow per link
  always_ff @(posedge sys_clk) begin
    if (!reset_n) en_r <= '{default: 8'h00};
    else if (cmt && address[9:2] == RPS_IDX_PAY_EN)
      en_r[address[11:10]] <= writedata[7:0] & 8'h0F;
  end
  // Signaling config shadow per link
  always_ff @(posedge sys_clk) begin
    if (!reset_n) cfg_r <= '{default: 8'h01};
    else if (cmt && address[9:2] == RPS_IDX_SIG_CFG)
      cfg_r[address[11:10]] <= writedata[7:0] & 8'h0F;
  end
  property p_wait_one;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");
  property p_wait_high;
    !waitrequest |=> waitrequest;
  endproperty
  a_wait_high: assert property (p_wait_high) else $error("waitrequest low twice");
  property p_route;
    sig_valid && sig_chan < 5'h18 |=> sig_out_valid && sig_out_link == $past(sig_link)
      && sig_out_chan == $past(sig_chan);
  endproperty
  a_route: assert property (p_route) else $error("signaling output misrouted");
  property p_no_out;
    !$past(sig_valid) |-> !sig_out_valid;
  endproperty
  a_no_out: assert property (p_no_out) else $error("spurious signaling output");
  property p_force;
    sig_valid && sig_chan < 5'h18 && frc |=> rx_signaling_out == {4{$past(lvl)}};
  endproperty
  a_force: assert property (p_force) else $error("forced level not output");
  property p_irq_off;
    !$past(ie0) |-> !irq[0];
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
  property p_pay_pass;
    pay_valid && !pen |=> pay_out_byte == $past(pay_byte);
  endproperty
  a_pay_pass: assert property (p_pay_pass) else $error("disabled payload altered");
  property p_busy_rd;
    read && !waitrequest && (address[9:2] == RPS_IDX_SIG_STATUS
      || address[9:2] == RPS_IDX_PAY_STATUS) |-> readdata[7:0] == 8'h00;
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy outlived transfer");
  c_force: cover property (sig_valid && frc);
  c_ctl: cover property (cmt && address[9:2] == RPS_IDX_SIG_CTL);
  c_irq: cover property (irq[0]);
endmodule : rps_checker
bind rps_regs rps_checker rps_checker_inst (.sys_clk, .reset_n, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest, .sig_valid, .sig_link, .sig_chan,
  .sig_out_valid, .sig_out_link, .sig_out_chan, .rx_signaling_out, .pay_valid, .pay_link,
  .pay_byte, .pay_out_byte, .irq);
`default_nettype wire

// file: test/rps_host.sv
// Host processor model: Avalon-MM master plus indirect-port sequences.
// Assumes the slave answers by dropping waitrequest; waits are bounded.
`timescale 1ns/100ps
`default_nettype none
module rps_host
  import rps_pkg::*;
(
  input wire logic sys_clk,
  output logic [11:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  int hung = 0;
  // Idle bus from time zero
  initial {address, read, write, writedata, byteenable} = '0;
  // Request held until waitrequest is seen low at an edge
  task automatic xfer(input logic rd, input logic [11:0] a, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= {24'h0, d};
    byteenable <= 4'hF;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    if (n >= 64) begin
      hung++;
      testbench.summarize();
    end
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~{24'h0, d}; // Released lines show no stale value
  endtask : xfer
  // Busy polled first; write data goes ahead of the control write, read data is fetched after it
  task automatic ind(input logic sg, input logic rd, input logic [1:0] lk,
      input logic [6:0] loc, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] st, b;
    int n;
    st = sg ? RPS_IDX_SIG_STATUS : RPS_IDX_PAY_STATUS;
    n = 0;
    do begin
      xfer(1'b1, {lk, st, 2'b00}, 8'h00, b);
      n++;
    end while (b[0] !== 1'b0 && n < 16);
    if (n >= 16) begin
      hung++;
      testbench.summarize();
    end
    q = d;
    if (!rd) xfer(1'b0, {lk, st + 8'h02, 2'b00}, d, b);
    xfer(1'b0, {lk, st + 8'h01, 2'b00}, {rd, loc}, b);
    if (rd) xfer(1'b1, {lk, st + 8'h02, 2'b00}, 8'h00, q);
  endtask : ind
endmodule : rps_host
`default_nettype wire

// file: test/testbench.sv
// Bench for rps_regs: host model on the bus, framer strobes from here.
// Assumes the checker binds itself to rps_regs.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rps_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] address;
  logic read, write, waitrequest, sig_valid, sig_first_frame, sig_in_sync, sig_esf;
  logic sig_out_valid, pay_valid, pay_out_valid;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable, rx_signaling_out, irq, n, m;
  logic [1:0] sig_link, sig_out_link, pay_link, pay_out_link, lk;
  logic [4:0] sig_chan, sig_out_chan, pay_chan, pay_out_chan, ch;
  logic [7:0] sig_byte, pay_byte, pay_out_byte, q, t, fi, fb;
  logic [6:0] locs [6] = '{7'h01, 7'h18, 7'h21, 7'h38, 7'h41, 7'h58};
  logic [15:0] subs [4] = '{16'h006E, 16'h016E, 16'h02A5, 16'h033C};
  logic [3:0] sq [$];
  logic [7:0] pq [$];
  int err_total = 0;
  int total_checks = 0;
  int seed = 32'h9fa1c2b1;
  // Milliwatt patterns with equal bytes, so the phase cannot matter
  rps_regs #(.ALAW_MW_PATTERN({8{8'hA5}}), .MULAW_MW_PATTERN({8{8'h3C}})) rps_regs_inst (
    .sys_clk, .reset_n, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .sig_valid, .sig_link, .sig_chan, .sig_byte, .sig_first_frame,
    .sig_in_sync, .sig_esf, .sig_out_valid, .sig_out_link, .sig_out_chan,
    .rx_signaling_out, .pay_valid, .pay_link, .pay_chan, .pay_byte, .pay_out_valid,
    .pay_out_link, .pay_out_chan, .pay_out_byte, .irq);
  rps_host rps_host_inst (.sys_clk, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest);
  always #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    err_total += rps_host_inst.hung;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    rps_host_inst.xfer(1'b0, {lk, idx, 2'b00}, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    rps_host_inst.xfer(1'b1, {lk, idx, 2'b00}, 8'h00, q);
    chk(q, e);
  endtask : rd
  task automatic ind(input logic sg, input logic r, input logic [6:0] loc, input logic [7:0] d);
    rps_host_inst.ind(sg, r, lk, loc, d, q);
  endtask : ind
  // One codeword for lk/ch; the expected output goes on the queue
  task automatic sig(input logic [7:0] b, input logic ff, input logic [3:0] e);
    @(posedge sys_clk);
    {sig_valid, sig_link, sig_chan, sig_byte, sig_first_frame} <= {1'b1, lk, ch, b, ff};
    sq.push_back(e);
    @(posedge sys_clk);
    sig_valid <= 1'b0;
    sig_byte <= ~b;
  endtask : sig
  task automatic pay(input logic [7:0] b, input logic [7:0] e);
    @(posedge sys_clk);
    {pay_valid, pay_link, pay_chan, pay_byte} <= {1'b1, lk, ch, b};
    pq.push_back(e);
    @(posedge sys_clk);
    pay_valid <= 1'b0;
    pay_byte <= ~b;
  endtask : pay
  // Each result takes the oldest note
  always @(posedge sys_clk) begin
    if (sig_out_valid === 1'b1 && sq.size() > 0)
      chk({4'h0, rx_signaling_out}, {4'h0, sq.pop_front()});
    if (pay_out_valid === 1'b1 && pq.size() > 0) begin
      chk(pay_out_byte, pq.pop_front());
      chk({1'b0, pay_out_link, pay_out_chan}, {1'b0, lk, ch});
    end
  end
  // Hang guard
  initial begin
    repeat (50000) @(posedge sys_clk);
    err_total++;
    summarize();
  end
  // Main sequence
  initial begin
    {sig_valid, sig_first_frame, sig_in_sync, sig_esf, pay_valid} = 5'h00;
    {sig_link, sig_chan, sig_byte, pay_link, pay_chan, pay_byte, lk, ch} = 37'h0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i += 3) begin
      lk = 2'(i);
      rd(RPS_IDX_PAY_CFG, 8'h80);
      rd(RPS_IDX_PAY_EN, 8'h00);
      rd(RPS_IDX_SIG_CFG, 8'h01);
      rd(RPS_IDX_SIG_STATUS, 8'h00);
      rd(RPS_IDX_FLAGS2, 8'h00);
      rd(8'hE0, 8'h00);
    end
    wr(RPS_IDX_PAY_EN, 8'hFF);
    rd(RPS_IDX_PAY_EN, 8'h0F);
    // Indirect round trips at range edges, then refused locations
    lk = 2'($random(seed));
    foreach (locs[i]) begin
      t = 8'($random(seed));
      ind(1'b0, 1'b0, locs[i], t);
      ind(1'b0, 1'b1, locs[i], 8'h00);
      chk(q, t);
    end
    ind(1'b1, 1'b0, 7'h18, t);
    ind(1'b1, 1'b1, 7'h18, 8'h00);
    chk(q & 8'h0F, t & 8'h0F);
    ind(1'b1, 1'b0, 7'h19, t);
    ind(1'b1, 1'b1, 7'h19, 8'h00);
    chk(q, 8'h00);
    ind(1'b0, 1'b1, 7'h59, 8'h00);
    chk(q, 8'h00);
    // Output overrides on a random channel: force, then global trunk, then per-channel trunk
    ch = 5'($unsigned($random(seed)) % 24);
    wr(RPS_IDX_PAY_EN, 8'h07);
    sig(8'h00, 1'b0, 4'hF);
    wr(RPS_IDX_PAY_EN, 8'h05);
    sig(8'h0F, 1'b0, 4'h0);
    wr(RPS_IDX_PAY_EN, 8'h01);
    wr(RPS_IDX_PAY_CFG, 8'h40);
    ind(1'b0, 1'b0, 7'h41 + 7'(ch), 8'h0A);
    sig(8'h03, 1'b0, 4'hA);
    wr(RPS_IDX_PAY_CFG, 8'h00);
    ind(1'b0, 1'b0, 7'h41 + 7'(ch), 8'h15);
    sig(8'h03, 1'b0, 4'h5);
    ind(1'b0, 1'b0, 7'h41 + 7'(ch), 8'h00);
    // Store, change flag and interrupt; output pinned high meanwhile
    fi = RPS_IDX_FLAGS0 + 8'(ch / 8);
    fb = 8'h01 << (ch % 8);
    n = 4'($random(seed)) | 4'h1;
    m = n ^ 4'h5;
    wr(RPS_IDX_PAY_EN, 8'h07);
    wr(RPS_IDX_SIG_CFG, 8'h03);
    ind(1'b1, 1'b0, 7'h01 + 7'(ch), 8'h00);
    wr(fi, 8'hFF);
    sig({4'h0, n}, 1'b0, 4'hF);
    ind(1'b1, 1'b1, 7'h01 + 7'(ch), 8'h00);
    chk(q & 8'h0F, {4'h0, n});
    rd(fi, fb);
    chk({7'h0, irq[lk]}, 8'h01);
    wr(fi, 8'h00);
    rd(fi, fb);
    wr(fi, fb);
    rd(fi, 8'h00);
    chk({7'h0, irq[lk]}, 8'h00);
    wr(RPS_IDX_SIG_CFG, 8'h0B);
    sig({4'h0, ~n}, 1'b0, 4'hF);
    ind(1'b1, 1'b1, 7'h01 + 7'(ch), 8'h00);
    chk(q & 8'h0F, {4'h0, n});
    wr(RPS_IDX_SIG_CFG, 8'h07);
    sig({4'h0, m}, 1'b0, 4'hF);
    ind(1'b1, 1'b1, 7'h01 + 7'(ch), 8'h00);
    chk(q & 8'h0F, {4'h0, n});
    sig({4'h0, m}, 1'b0, 4'hF);
    ind(1'b1, 1'b1, 7'h01 + 7'(ch), 8'h00);
    chk(q & 8'h0F, {4'h0, m});
    // Snapshot holds the first frame across the superframe
    wr(RPS_IDX_PAY_EN, 8'h01);
    wr(RPS_IDX_SIG_CFG, 8'h01);
    wr(RPS_IDX_PAY_CFG, 8'h80);
    sig_in_sync <= 1'b1;
    sig(8'h0C, 1'b1, 4'hC);
    sig(8'h05, 1'b0, 4'hC);
    // ESF: four-state keeps C and D; position takes the upper pair
    sig_esf <= 1'b1;
    wr(RPS_IDX_SIG_CFG, 8'h00);
    sig(8'h0A, 1'b1, 4'h9);
    wr(RPS_IDX_SIG_CFG, 8'h01);
    wr(RPS_IDX_PAY_EN, 8'h09);
    sig(8'h0B, 1'b1, 4'h8);
    // Every substitution code, then disabled pass-through
    t = 8'($random(seed));
    ind(1'b0, 1'b0, 7'h21 + 7'(ch), 8'h6E);
    ind(1'b0, 1'b0, 7'h01 + 7'(ch), 8'h20);
    foreach (subs[i]) begin
      wr(RPS_IDX_PAY_CFG, subs[i][15:8]);
      pay(t, subs[i][7:0]);
    end
    wr(RPS_IDX_PAY_EN, 8'h00);
    pay(t, t);
    repeat (4) @(posedge sys_clk);
    chk(8'(sq.size() + pq.size()), 8'h00);
    summarize();
  end
endmodule : testbench
`default_nettype wire
